/* sbs_defs.svh */
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH

// timing
`define SBS_CLK_PERIOD_NS       100
`define SBS_TICK_UNIT_NS        100000
`define SBS_TICKS_PER_MS        10
`define SBS_INDEX_DEFAULT_TICKS 16'h000A

// register byte offsets
`define SBS_ADR_CTRL            8'h00
`define SBS_ADR_TORQUE          8'h04
`define SBS_ADR_TIME            8'h08
`define SBS_ADR_CMD_DELAY       8'h0C
`define SBS_ADR_STATIC_DELAY    8'h10
`define SBS_ADR_THRESH          8'h14
`define SBS_ADR_MAX_WAIT        8'h18
`define SBS_ADR_INDEX_WIDTH     8'h1C
`define SBS_ADR_STATUS          8'h20

// upper limits of the settings
`define SBS_METHOD_MAX          32'h00000002
`define SBS_ACTION_MAX          32'h00000002
`define SBS_TORQUE_MAX          32'h0000015E
`define SBS_TIME_MAX            32'h0000EA60
`define SBS_DELAY_MAX           32'h000001F4
`define SBS_THRESH_MAX          32'h00001770
`define SBS_WAIT_MAX            32'h000003E8
`define SBS_INDEX_MAX           32'h000003E8

// control register fields
`define SBS_CTRL_METHOD_LSB     0
`define SBS_CTRL_ACTION_LSB     2

// status register fields
`define SBS_STAT_BRAKE_BIT      0
`define SBS_STAT_POWER_BIT      1
`define SBS_STAT_ACCEPT_BIT     2
`define SBS_STAT_DECEL_BIT      3
`define SBS_STAT_DB_BIT         4
`define SBS_STAT_INDEX_BIT      5
`define SBS_STAT_STATE_LSB      8

// stop method and base action codes
`define SBS_METHOD_BASE         2'h0
`define SBS_METHOD_TORQUE       2'h1
`define SBS_METHOD_TIME         2'h2
`define SBS_ACTION_DB_HOLD      2'h0
`define SBS_ACTION_DB_RELEASE   2'h1
`define SBS_ACTION_COAST        2'h2

// reset values
`define SBS_RST_METHOD          2'h0
`define SBS_RST_ACTION          2'h0
`define SBS_RST_VALUE           32'h00000000

// timer slots
`define SBS_TMR_SEQ             0
`define SBS_TMR_DECEL           1
`define SBS_TMR_INDEX           2
`define SBS_TMR_COUNT           3

`endif

/* sbs_pkg.sv */
package sbs_pkg;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_ENABLING,
		ST_RUN,
		ST_BRAKE_HOLD,
		ST_BRAKE_WAIT,
		ST_DECEL,
		ST_BASE
	} seq_state_type;

	typedef struct packed {
		logic [1:0]  stop_method_select;
		logic [1:0]  base_stop_action;
		logic [8:0]  stop_decel_torque;
		logic [15:0] stop_decel_time;
		logic [8:0]  brake_release_cmd_delay;
		logic [8:0]  static_brake_power_delay;
		logic [12:0] brake_speed_threshold;
		logic [9:0]  rotating_brake_max_wait;
		logic [9:0]  index_pulse_width;
	} cfg_type;

	typedef struct packed {
		logic brake_release;
		logic power_on;
		logic dynamic_braking;
		logic cmd_accept;
		logic decel_active;
		logic torque_limit_en;
	} drive_ctrl_type;

endpackage

/* interval_timer.sv */
`timescale 1ns/1ns
module interval_timer (
	// clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	// control
	input  wire logic        load_in,
	input  wire logic [15:0] load_value_in,
	input  wire logic        tick_in,
	// state
	output logic      [15:0] count_out,
	output logic             expired_out
);

	// load wins over a tick arriving in the same cycle
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			count_out <= 16'h0000;
		end else if (load_in) begin
			count_out <= load_value_in;
		end else if (tick_in && count_out != 16'h0000) begin
			count_out <= count_out - 16'h0001;
		end
	end

	assign expired_out = (count_out == 16'h0000);

endmodule

/* servo_brake_stop_sequencer.sv */
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`include "sbs_defs.svh"
// Contract
// R01 - method 1: decelerate with the set torque, then apply base stop action
// R02 - method 2: stop within the set decel time, then apply base action
// R03 - stop decel torque is settable from 0 to 350 percent
// R04 - stop decel time is settable from 0 to 60000 ms
// R05 - after brake release wait 0 to 500 ms before accepting commands
// R06 - after enable accept position commands only once static delay elapsed
// R07 - enable off at standstill: brake on, keep power for static delay
// R08 - enable off rotating: brake once speed below threshold, else wait
// R09 - rotating brake wait up to 0..1000 ms, then brake regardless of speed
// R10 - index pulse uses default width at 0, else setting times 0.1 ms
// R11 - base action: 0 hold braking, 1 brake then release, 2 coast
// R12 - stop method, torque and time are frozen while a stop runs
// R13 - deceleration ends, and base action begins, at zero speed
module servo_brake_stop_sequencer
	import sbs_pkg::*;
#(
	parameter int TICK_CYCLES = `SBS_TICK_UNIT_NS / `SBS_CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	// wishbone slave
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	// host and feedback
	input  wire logic        enable_cmd_in,
	input  wire logic        stop_req_in,
	input  wire logic [12:0] motor_speed_in,
	input  wire logic        index_in,
	// power stage, brake and index
	output drive_ctrl_type   drive_ctrl_out,
	output logic      [8:0]  decel_torque_out,
	output logic      [15:0] decel_time_left_out,
	output logic             index_pulse_out
);

	cfg_type       cfg;
	seq_state_type state;
	seq_state_type next_state;
	logic [15:0]   pre_count;
	logic [3:0]    ms_div;
	logic          tick_unit;
	logic          tick_ms;
	logic          index_q;
	logic          index_edge;
	logic          capture;
	logic [1:0]    cap_method;
	logic [1:0]    cap_action;
	logic [15:0]   cap_time;
	logic          standstill;
	logic          below_thresh;
	logic          bus_req;
	logic          bus_wr;
	logic [31:0]   wr_word;
	logic [31:0]   status_word;
	logic [31:0]   next_rd;
	logic          tmr_load    [`SBS_TMR_COUNT];
	logic [15:0]   tmr_value   [`SBS_TMR_COUNT];
	logic          tmr_tick    [`SBS_TMR_COUNT];
	logic [15:0]   tmr_count   [`SBS_TMR_COUNT];
	logic          tmr_expired [`SBS_TMR_COUNT];

	assign standstill   = (motor_speed_in == 13'h0000);
	assign below_thresh = (motor_speed_in < cfg.brake_speed_threshold);
	assign bus_req      = wb_cyc_in && wb_stb_in && !wb_ack_out;
	// a write commits at the edge where the master samples ack high
	assign bus_wr       = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;
	assign index_edge   = index_in && !index_q;

	// free-running 0.1 ms base; the enable, static power and set index width
	// timers load one tick extra so that their wait is never shorter than its setting
	assign tick_unit = (pre_count == 16'(TICK_CYCLES - 1));
	assign tick_ms   = tick_unit && (ms_div == 4'(`SBS_TICKS_PER_MS - 1));

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			pre_count <= 16'h0000;
			ms_div    <= 4'h0;
		end else if (tick_unit) begin
			pre_count <= 16'h0000;
			ms_div    <= tick_ms ? 4'h0 : ms_div + 4'h1;
		end else begin
			pre_count <= pre_count + 16'h0001;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `SBS_TMR_COUNT; gi++) begin : g_tmr
			interval_timer u_tmr (
				.core_clk_in   (core_clk_in),
				.rst_n_in      (rst_n_in),
				.load_in       (tmr_load[gi]),
				.load_value_in (tmr_value[gi]),
				.tick_in       (tmr_tick[gi]),
				.count_out     (tmr_count[gi]),
				.expired_out   (tmr_expired[gi])
			);
		end
	endgenerate

	assign tmr_tick[`SBS_TMR_SEQ]   = tick_ms;
	assign tmr_tick[`SBS_TMR_DECEL] = tick_ms;
	assign tmr_tick[`SBS_TMR_INDEX] = tick_unit;

	// registers: writes merge by byte lane and saturate at the top of range
	function automatic logic [31:0] merge(input logic [31:0] old_val,
			input logic [31:0] wr_val, input logic [3:0] sel);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = wr_val[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [31:0] sat(input logic [31:0] v,
			input logic [31:0] lim);
		return (v > lim) ? lim : v;
	endfunction

	// next_rd already holds the addressed register's present image
	assign wr_word = merge(next_rd, wb_dat_in, wb_sel_in);

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			cfg <= '0;
			cfg.stop_method_select <= `SBS_RST_METHOD;
			cfg.base_stop_action   <= `SBS_RST_ACTION;
		end else if (bus_wr) begin
			unique case (wb_adr_in)
				`SBS_ADR_CTRL: begin
					cfg.stop_method_select <= 2'(sat(
						32'(wr_word[`SBS_CTRL_METHOD_LSB +: 2]),
						`SBS_METHOD_MAX));
					cfg.base_stop_action <= 2'(sat(
						32'(wr_word[`SBS_CTRL_ACTION_LSB +: 2]),
						`SBS_ACTION_MAX));
				end
				`SBS_ADR_TORQUE: begin
					cfg.stop_decel_torque <=
						9'(sat(wr_word, `SBS_TORQUE_MAX)); // R03
				end
				`SBS_ADR_TIME: begin
					cfg.stop_decel_time <=
						16'(sat(wr_word, `SBS_TIME_MAX)); // R04
				end
				`SBS_ADR_CMD_DELAY: begin
					cfg.brake_release_cmd_delay <=
						9'(sat(wr_word, `SBS_DELAY_MAX)); // R05
				end
				`SBS_ADR_STATIC_DELAY: begin
					cfg.static_brake_power_delay <=
						9'(sat(wr_word, `SBS_DELAY_MAX));
				end
				`SBS_ADR_THRESH: begin
					cfg.brake_speed_threshold <=
						13'(sat(wr_word, `SBS_THRESH_MAX)); // R08
				end
				`SBS_ADR_MAX_WAIT: begin
					cfg.rotating_brake_max_wait <=
						10'(sat(wr_word, `SBS_WAIT_MAX)); // R09
				end
				`SBS_ADR_INDEX_WIDTH: begin
					cfg.index_pulse_width <=
						10'(sat(wr_word, `SBS_INDEX_MAX)); // R10
				end
				default: begin
					// unmapped and status: write ignored, still acked
				end
			endcase
		end
	end

	always_comb begin
		status_word = 32'h00000000;
		status_word[`SBS_STAT_BRAKE_BIT]  = drive_ctrl_out.brake_release;
		status_word[`SBS_STAT_POWER_BIT]  = drive_ctrl_out.power_on;
		status_word[`SBS_STAT_ACCEPT_BIT] = drive_ctrl_out.cmd_accept;
		status_word[`SBS_STAT_DECEL_BIT]  = drive_ctrl_out.decel_active;
		status_word[`SBS_STAT_DB_BIT]     = drive_ctrl_out.dynamic_braking;
		status_word[`SBS_STAT_INDEX_BIT]  = index_pulse_out;
		status_word[`SBS_STAT_STATE_LSB +: 3] = state;
		unique case (wb_adr_in)
			`SBS_ADR_CTRL:         next_rd = {28'h0000000, cfg.base_stop_action,
				cfg.stop_method_select};
			`SBS_ADR_TORQUE:       next_rd = 32'(cfg.stop_decel_torque);
			`SBS_ADR_TIME:         next_rd = 32'(cfg.stop_decel_time);
			`SBS_ADR_CMD_DELAY:    next_rd = 32'(cfg.brake_release_cmd_delay);
			`SBS_ADR_STATIC_DELAY: next_rd = 32'(cfg.static_brake_power_delay);
			`SBS_ADR_THRESH:       next_rd = 32'(cfg.brake_speed_threshold);
			`SBS_ADR_MAX_WAIT:     next_rd = 32'(cfg.rotating_brake_max_wait);
			`SBS_ADR_INDEX_WIDTH:  next_rd = 32'(cfg.index_pulse_width);
			`SBS_ADR_STATUS:       next_rd = status_word;
			default:               next_rd = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= bus_req;
			if (bus_req && !wb_we_in) begin
				wb_dat_out <= next_rd;
			end
		end
	end

	// sequencer: one timer serves the enable, brake and power steps
	always_comb begin
		logic [8:0] longer;
		longer = (cfg.brake_release_cmd_delay > cfg.static_brake_power_delay)
			? cfg.brake_release_cmd_delay : cfg.static_brake_power_delay;
		next_state = state;
		capture    = 1'b0;
		tmr_load[`SBS_TMR_SEQ]    = 1'b0;
		tmr_value[`SBS_TMR_SEQ]   = 16'h0000;
		tmr_load[`SBS_TMR_DECEL]  = 1'b0;
		tmr_value[`SBS_TMR_DECEL] = cfg.stop_decel_time;
		if (stop_req_in && state != ST_OFF && state != ST_DECEL
				&& state != ST_BASE) begin
			capture = 1'b1; // R12
			tmr_load[`SBS_TMR_DECEL] = 1'b1; // R02
			if (cfg.stop_method_select == `SBS_METHOD_BASE) begin
				next_state = ST_BASE;
			end else begin
				next_state = ST_DECEL; // R01 R02
			end
		end else begin
			unique case (state)
				ST_OFF: begin
					if (enable_cmd_in && !stop_req_in) begin
						next_state = ST_ENABLING;
						tmr_load[`SBS_TMR_SEQ]  = 1'b1;
						tmr_value[`SBS_TMR_SEQ] = 16'(longer) + 16'h0001; // R05 R06
					end
				end
				ST_ENABLING, ST_RUN: begin
					if (!enable_cmd_in && standstill) begin
						next_state = ST_BRAKE_HOLD; // R07
						tmr_load[`SBS_TMR_SEQ]  = 1'b1;
						tmr_value[`SBS_TMR_SEQ] =
							16'(cfg.static_brake_power_delay) + 16'h0001;
					end else if (!enable_cmd_in) begin
						next_state = ST_BRAKE_WAIT; // R08
						tmr_load[`SBS_TMR_SEQ]  = 1'b1;
						tmr_value[`SBS_TMR_SEQ] =
							16'(cfg.rotating_brake_max_wait); // R09
					end else if (state == ST_ENABLING
							&& tmr_expired[`SBS_TMR_SEQ]) begin
						next_state = ST_RUN; // R05 R06
					end
				end
				ST_BRAKE_HOLD: begin
					if (tmr_expired[`SBS_TMR_SEQ]) begin
						next_state = ST_OFF; // R07
					end
				end
				ST_BRAKE_WAIT: begin
					if (below_thresh || tmr_expired[`SBS_TMR_SEQ]) begin
						next_state = ST_OFF; // R08 R09
					end
				end
				ST_DECEL: begin
					if (standstill) begin
						next_state = ST_BASE; // R13
					end
				end
				ST_BASE: begin
					if (!stop_req_in && !enable_cmd_in) begin
						next_state = ST_OFF;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// stop settings are frozen for the whole stop; edits apply to the next
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			cap_method       <= `SBS_RST_METHOD;
			cap_action       <= `SBS_RST_ACTION;
			cap_time         <= 16'h0000;
			decel_torque_out <= 9'h000;
		end else if (capture) begin
			cap_method       <= cfg.stop_method_select; // R12
			cap_action       <= cfg.base_stop_action;
			cap_time         <= cfg.stop_decel_time;
			decel_torque_out <= cfg.stop_decel_torque;
		end
	end

	// remaining time lets the speed loop ramp so rest is reached in time
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			decel_time_left_out <= 16'h0000;
		end else if (next_state == ST_DECEL
				&& (capture ? cfg.stop_method_select : cap_method)
				== `SBS_METHOD_TIME) begin
			decel_time_left_out <= capture ? cfg.stop_decel_time
				: tmr_count[`SBS_TMR_DECEL]; // R02
		end else begin
			decel_time_left_out <= 16'h0000;
		end
	end

	always_comb begin
		drive_ctrl_out.brake_release = (state == ST_ENABLING)
			|| (state == ST_RUN) || (state == ST_BRAKE_WAIT)
			|| (state == ST_DECEL);
		drive_ctrl_out.power_on = (state != ST_OFF) && (state != ST_BASE);
		drive_ctrl_out.cmd_accept      = (state == ST_RUN); // R06
		drive_ctrl_out.decel_active    = (state == ST_DECEL);
		drive_ctrl_out.torque_limit_en = (state == ST_DECEL)
			&& (cap_method == `SBS_METHOD_TORQUE); // R01
		drive_ctrl_out.dynamic_braking = (state == ST_BASE)
			&& ((cap_action == `SBS_ACTION_DB_HOLD)
			|| (cap_action == `SBS_ACTION_DB_RELEASE && !standstill)); // R11
	end

	// index pulse stretcher; a new edge restarts the width
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			index_q <= 1'b0;
		end else begin
			index_q <= index_in;
		end
	end

	assign tmr_load[`SBS_TMR_INDEX]  = index_edge;
	assign tmr_value[`SBS_TMR_INDEX] = (cfg.index_pulse_width == 10'h000)
		? `SBS_INDEX_DEFAULT_TICKS
		: 16'(cfg.index_pulse_width) + 16'h0001; // R10
	assign index_pulse_out = !tmr_expired[`SBS_TMR_INDEX];

	sequence s_stand_off;
		state == ST_RUN && !enable_cmd_in && standstill && !stop_req_in;
	endsequence
	sequence s_brake_held_powered;
		!drive_ctrl_out.brake_release && drive_ctrl_out.power_on;
	endsequence

	property p_static_hold;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		s_stand_off |=> s_brake_held_powered ##1 s_brake_held_powered;
	endproperty
	a_static_hold: assert property (p_static_hold) // R07
		else $error("standstill enable off did not hold power with brake");

	property p_accept_gated;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		$rose(drive_ctrl_out.cmd_accept) |->
			$past(state) == ST_ENABLING && $past(tmr_expired[`SBS_TMR_SEQ]);
	endproperty
	a_accept_gated: assert property (p_accept_gated) // R06
		else $error("commands accepted before the enable delay elapsed");

	property p_enabling_waits;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		$rose(state == ST_ENABLING) |->
			!drive_ctrl_out.cmd_accept [*2] ##0 drive_ctrl_out.brake_release;
	endproperty
	a_enabling_waits: assert property (p_enabling_waits) // R05
		else $error("command accept not held off after brake release");

	property p_thresh_brake;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		state == ST_BRAKE_WAIT && below_thresh && !stop_req_in |=>
			!drive_ctrl_out.brake_release;
	endproperty
	a_thresh_brake: assert property (p_thresh_brake) // R08
		else $error("brake not applied below speed threshold");

	property p_wait_expiry;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		state == ST_BRAKE_WAIT && tmr_expired[`SBS_TMR_SEQ] && !stop_req_in
			|=> state == ST_OFF && !drive_ctrl_out.brake_release;
	endproperty
	a_wait_expiry: assert property (p_wait_expiry) // R09
		else $error("brake not applied when the wait expired");

	property p_index_start;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		index_edge |=> index_pulse_out ##1 index_pulse_out;
	endproperty
	a_index_start: assert property (p_index_start) // R10
		else $error("index pulse not stretched");

	property p_decel_frozen;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		state == ST_DECEL && $past(state) == ST_DECEL |->
			$stable(decel_torque_out) && $stable(cap_method)
			&& $stable(cap_time);
	endproperty
	a_decel_frozen: assert property (p_decel_frozen) // R12
		else $error("stop settings changed during a stop");

	property p_zero_speed_end;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		state == ST_DECEL && standstill |=> state == ST_BASE
			&& !drive_ctrl_out.power_on;
	endproperty
	a_zero_speed_end: assert property (p_zero_speed_end) // R13
		else $error("deceleration did not end at zero speed");

	property p_torque_method;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		capture && cfg.stop_method_select == `SBS_METHOD_TORQUE |=>
			drive_ctrl_out.torque_limit_en
			&& decel_torque_out == $past(cfg.stop_decel_torque);
	endproperty
	a_torque_method: assert property (p_torque_method) // R01
		else $error("torque limited stop not started with set torque");

	property p_coast;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		state == ST_BASE && cap_action == `SBS_ACTION_COAST |->
			!drive_ctrl_out.dynamic_braking && !drive_ctrl_out.power_on;
	endproperty
	a_coast: assert property (p_coast) // R11
		else $error("coast action applied dynamic braking");

	property p_limits;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		32'(cfg.stop_decel_torque) <= `SBS_TORQUE_MAX
			&& 32'(cfg.stop_decel_time) <= `SBS_TIME_MAX;
	endproperty
	a_limits: assert property (p_limits) // R03 R04
		else $error("stop torque or time setting out of range");

endmodule

/* motor_model.sv */
`timescale 1ns/1ns
module motor_model
	import sbs_pkg::*;
(
	// clock
	input  wire logic           core_clk_in,
	// drive side
	input  wire drive_ctrl_type drive_ctrl_in,
	input  wire logic [12:0]    target_in,
	// feedback
	output logic      [12:0]    speed_out
);
	logic bleed;

	// a closed brake, dead stage or controlled stop bleeds one rpm a cycle;
	// a real load never jumps to rest, so zero speed arrives late
	assign bleed = drive_ctrl_in.decel_active || !drive_ctrl_in.power_on
		|| !drive_ctrl_in.brake_release;

	initial speed_out = 13'h0000;

	always @(posedge core_clk_in) begin
		if (!bleed)
			speed_out <= target_in;
		else if (speed_out != 13'h0000)
			speed_out <= speed_out - 13'h0001;
	end
endmodule

/* testbench.sv */
`timescale 1ns/1ns
module testbench
	import sbs_pkg::*;
;
	localparam int TICK = 4;
	localparam int MS   = 10 * TICK;

	logic           core_clk, rst_n, cyc, stb, we, en, stop, idx, ack, ipulse;
	logic [7:0]     adr;
	logic [31:0]    wdat, rdat, dout;
	logic [12:0]    speed, target;
	logic [8:0]     tq_out;
	logic [15:0]    tleft;
	drive_ctrl_type dc;
	int             fail_count, cmp_count;
	int             seed = 32'h795BB2B6;
	int             sat[8] = '{10, 350, 60000, 500, 500, 6000, 1000, 1000};
	int             exp_q[$];

	servo_brake_stop_sequencer #(.TICK_CYCLES(TICK))
	servo_brake_stop_sequencer_i (
		.core_clk_in(core_clk), .rst_n_in(rst_n), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
		.wb_dat_in(wdat), .wb_dat_out(dout), .wb_ack_out(ack),
		.enable_cmd_in(en), .stop_req_in(stop), .motor_speed_in(speed),
		.index_in(idx), .drive_ctrl_out(dc), .decel_torque_out(tq_out),
		.decel_time_left_out(tleft), .index_pulse_out(ipulse));

	motor_model motor_model_i (.core_clk_in(core_clk), .drive_ctrl_in(dc),
		.target_in(target), .speed_out(speed));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi,
			input int n);
		cmp_count++;
		if (n < lo || n > hi) begin
			fail_count++;
			$display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, n);
		end
	endtask

	// entered and left just after a rising edge; request held until ack
	task automatic wb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1);
		chk("ack latency", 32'd2, 32'(n));
		rdat = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic cfg(input int v[8]);
		for (int i = 0; i < 8; i++)
			wb(1'b1, 8'(i * 4), 32'(v[i]));
	endtask

	task automatic wait_bit(input int b, input logic v, output int n);
		n = 0;
		while (dc[b] !== v && n < 5000) begin
			@(posedge core_clk);
			n++;
		end
	endtask

	initial begin
		repeat (40000) @(posedge core_clk);
		fail_count++;
		summarize();
	end

	initial begin
		int v, n, m, a, tq;
		{rst_n, cyc, stb, we, en, stop, idx} = 7'h00;
		adr = 8'h00;
		wdat = 32'h00000000;
		target = 13'h0000;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < 10; i++) begin
			wb(1'b0, 8'(i * 4), 32'h00000000);
			chk("reset value", 32'h00000000, rdat);
		end
		wb(1'b1, 8'h20, 32'hFFFFFFFF);
		wb(1'b1, 8'h24, 32'hFFFFFFFF);
		wb(1'b0, 8'h24, 32'h00000000);
		chk("unmapped", 32'h00000000, rdat);
		wb(1'b0, 8'h20, 32'h00000000);
		chk("status ro", 32'h00000000, rdat);
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, 8'(i * 4), 32'hFFFFFFFF);
			wb(1'b0, 8'(i * 4), 32'h00000000);
			chk("saturated", sat[i], rdat);
			if (i > 0) begin
				v = $unsigned($random(seed)) % (sat[i] + 1);
				exp_q.push_back(v);
				wb(1'b1, 8'(i * 4), 32'(v));
				wb(1'b0, 8'(i * 4), 32'h00000000);
				chk("in range", exp_q.pop_front(), rdat);
			end
		end
		cfg('{0, 100, 5, 2, 3, 50, 2, 0});
		en <= 1'b1;
		wait_bit(2, 1'b1, n);
		chk_rng("accept delay", 3 * MS - 2, 4 * MS + 4, n);
		chk("brake open", 1'b1, dc.brake_release);
		en <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("hold brake", 1'b0, dc.brake_release);
		chk("hold power", 1'b1, dc.power_on);
		wait_bit(4, 1'b0, n);
		chk_rng("power delay", 3 * MS - 2, 4 * MS + 2, n);
		for (int k = 0; k < 2; k++) begin
			target <= 13'd100;
			en <= 1'b1;
			wait_bit(2, 1'b1, n);
			en <= 1'b0;
			repeat (2) @(posedge core_clk);
			chk("wait brake", 1'b1, dc.brake_release);
			chk("wait power", 1'b1, dc.power_on);
			if (k == 0)
				target <= 13'd30;
			wait_bit(5, 1'b0, n);
			if (k == 0)
				chk_rng("slow brake", 0, 3, n);
			else
				chk_rng("max wait", MS - 4, 2 * MS + 2, n);
		end
		for (int k = 0; k < 9; k++) begin
			m = k / 3;
			a = k % 3;
			tq = $unsigned($random(seed)) % 351;
			cfg('{m | (a << 2), tq, 5, 0, 0, 50, 2, 0});
			target <= 13'd40;
			en <= 1'b1;
			wait_bit(2, 1'b1, n);
			stop <= 1'b1;
			repeat (2) @(posedge core_clk);
			chk("decel", m != 0, dc.decel_active);
			chk("torque limit", m == 1, dc.torque_limit_en);
			chk("torque", tq, tq_out);
			if (m == 2)
				chk_rng("time left", 4, 5, int'(tleft));
			wb(1'b1, 8'h04, 32'(350 - tq));
			chk("torque held", tq, tq_out);
			wait_bit(1, 1'b0, n);
			chk_rng("decel end", 0, 60, n);
			if (m != 0)
				chk("stop speed", 0, speed);
			repeat (2) @(posedge core_clk);
			chk("base power", 1'b0, dc.power_on);
			chk("base brake", 1'b0, dc.brake_release);
			v = (a == 0 || (a == 1 && speed != 13'h0000));
			chk("braking", v, dc.dynamic_braking);
			stop <= 1'b0;
			en <= 1'b0;
			repeat (3) @(posedge core_clk);
			wb(1'b0, 8'h20, 32'h00000000);
			chk("off again", 0, rdat[10:8]);
		end
		for (int k = 0; k < 2; k++) begin
			v = k * (1 + $unsigned($random(seed)) % 20);
			wb(1'b1, 8'h1C, 32'(v));
			idx <= 1'b1;
			@(posedge core_clk);
			idx <= 1'b0;
			n = 0;
			repeat (120) begin
				@(posedge core_clk);
				if (ipulse === 1'b1)
					n++;
			end
			chk_rng("index width", (v == 0 ? 9 : v) * TICK - 1,
				(v == 0 ? 10 : v + 1) * TICK + 1, n);
		end
		summarize();
	end
endmodule
